// [design/crs_params.svh]
// Shared constants for the caller identification receive sequencer
`ifndef CRS_PARAMS_SVH
`define CRS_PARAMS_SVH
// Clock and time base
`define CRS_CLK_HZ 10000000
`define CRS_CYC_PER_MS (`CRS_CLK_HZ / 1000)
// Control select line codes
`define CRS_CS_POWER_DOWN_CTL 3'h0
`define CRS_CS_TONE_TR 3'h1
`define CRS_CS_TONE_HYB 3'h2
`define CRS_CS_FSK 3'h4
// Device timing in ms
`define CRS_GP_MS 10
`define CRS_DP_MS 1
`define CRS_GA_MS 15
`define CRS_DA_MS 1
`define CRS_CD_ON_MS 20
`define CRS_CD_OFF_MS 10
// Host timing in ms and limits
`define CRS_CD_TMO_MS 500
`define CRS_NOFSK_MS 500
`define CRS_MARKSPACE_MS 150
`define CRS_LOAD_HOLD_MS 100
`define CRS_FERR_MAX 5
// Host register byte addresses
`define CRS_A_CTRL 8'h00
`define CRS_A_STATUS 8'h04
`define CRS_A_CLEAR 8'h08
`define CRS_A_ENABLE 8'h0c
`define CRS_A_STATE 8'h10
// Control register fields
`define CRS_CTRL_START 0
`define CRS_CTRL_MODE_LO 1
`define CRS_CTRL_ADSI 3
`define CRS_CTRL_ABORT 4
// Status event bits
`define CRS_EV_CARRIER 0
`define CRS_EV_DONE 1
`define CRS_EV_CD_TMO 2
`define CRS_EV_FERR 3
`define CRS_EV_MARKSPACE 4
`define CRS_EV_NOFSK 5
`define CRS_EV_W 6
// Acknowledge digits
`define CRS_ACK_PLAIN 4'hd
`define CRS_ACK_ADSI 4'ha
`endif

// [design/crs_pkg.sv]
// Types for both ends of the receive sequencer, each used by one end
package crs_pkg;
  typedef enum logic [1:0] {
    MODE_RING, MODE_TONE_ONHOOK, MODE_OFFHOOK, MODE_RSVD
  } crs_mode_t;
  typedef enum {
    H_IDLE, H_RING_WAIT, H_TONE_WAIT, H_TONE_END, H_ACK,
    H_CD_WAIT, H_RECV, H_END_HOLD
  } crs_hstate_t;
  typedef struct packed {
    logic [2:0] pd_en_tone;
    logic hyb;
    logic [23:0] cd_cnt;
    logic [23:0] tone_cnt;
    logic carrier_n;
    logic tone_n;
    logic [1:0] ring_s;
    logic [1:0] fsk_s;
    logic [1:0] tone_s;
    logic [1:0] bit_s;
    logic [2:0] ferr_s;
    logic data;
    logic ferr;
  } crs_dev_t;
endpackage : crs_pkg

// [design/crs_link_if.sv]
// Pins between the receiver and the host controller
`timescale 1ns/1ps
`default_nettype none
interface crs_link_if;
  logic [2:0] control_select_lines;
  logic carrier_present_n;
  logic ready_or_tone_flag_n;
  logic fsk_data;
  logic frame_err;
  modport dev (input control_select_lines, output carrier_present_n,
    output ready_or_tone_flag_n, output fsk_data, output frame_err);
  modport host (output control_select_lines, input carrier_present_n,
    input ready_or_tone_flag_n, input fsk_data, input frame_err);
endinterface : crs_link_if
`default_nettype wire

// [design/crs_device.sv]
// Receiver end: control decode, carrier and tone qualification
`timescale 1ns/1ps
`default_nettype none
`include "crs_params.svh"
module crs_device #(
  parameter int GP_CYC = `CRS_GP_MS * `CRS_CYC_PER_MS,
  parameter int DP_CYC = `CRS_DP_MS * `CRS_CYC_PER_MS,
  parameter int GA_CYC = `CRS_GA_MS * `CRS_CYC_PER_MS,
  parameter int DA_CYC = `CRS_DA_MS * `CRS_CYC_PER_MS,
  parameter int CD_ON_CYC = `CRS_CD_ON_MS * `CRS_CYC_PER_MS,
  parameter int CD_OFF_CYC = `CRS_CD_OFF_MS * `CRS_CYC_PER_MS
) (
  // Clock, reset, enable
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic ce_in,
  // Link to the host
  crs_link_if.dev link,
  // Analog front end indications, asynchronous
  input wire logic ring_detect_in,
  input wire logic fsk_energy_in,
  input wire logic tone_energy_in,
  input wire logic fsk_bit_in,
  input wire logic frame_err_in,
  // Decoded internal enables
  output logic pwr_down_out,
  output logic fsk_on_out,
  output logic tone_on_out,
  output logic tone_hybrid_out
);
  localparam int TREC = GP_CYC + DP_CYC;
  localparam int TABS = GA_CYC + DA_CYC;
  generate
    if (TREC < 1 || TABS < 1 || CD_ON_CYC < 1 || CD_OFF_CYC < 1 ||
        TREC >= 2**24 || TABS >= 2**24 || CD_ON_CYC >= 2**24 ||
        CD_OFF_CYC >= 2**24) begin : g_bad
      $error("crs_device timing parameters out of range");
    end
  endgenerate

  // Map a select code onto power down, fsk, tone, hybrid input
  function automatic logic [3:0] crs_decode(input logic [2:0] cs);
    case (cs)
      `CRS_CS_TONE_TR: crs_decode = 4'h2;
      `CRS_CS_TONE_HYB: crs_decode = 4'h3;
      `CRS_CS_FSK: crs_decode = 4'h4;
      default: crs_decode = 4'h8;
    endcase
  endfunction : crs_decode

  crs_pkg::crs_dev_t st_reg, st_next;
  logic [3:0] dec;

  always_comb begin
    dec = crs_decode(link.control_select_lines);
    st_next = st_reg;
    // Pin inputs pass two flops before use
    st_next.ring_s = {st_reg.ring_s[0], ring_detect_in};
    st_next.fsk_s = {st_reg.fsk_s[0], fsk_energy_in};
    st_next.tone_s = {st_reg.tone_s[0], tone_energy_in};
    st_next.bit_s = {st_reg.bit_s[0], fsk_bit_in};
    st_next.ferr_s = {st_reg.ferr_s[1:0], frame_err_in};
    st_next.pd_en_tone = {dec[3], dec[2], dec[1]};
    st_next.hyb = dec[0];
    // Carrier: ringing energy never counts as carrier
    if (!dec[2]) begin
      st_next.carrier_n = 1'b1;
      st_next.cd_cnt = '0;
    end else if (st_reg.carrier_n) begin
      if (st_reg.fsk_s[1] && !st_reg.ring_s[1]) begin
        if (st_reg.cd_cnt >= 24'(CD_ON_CYC - 1)) begin
          st_next.carrier_n = 1'b0;
          st_next.cd_cnt = '0;
        end else begin
          st_next.cd_cnt = st_reg.cd_cnt + 24'h1;
        end
      end else begin
        st_next.cd_cnt = '0;
      end
    end else if (!st_reg.fsk_s[1] || st_reg.ring_s[1]) begin
      if (st_reg.cd_cnt >= 24'(CD_OFF_CYC - 1)) begin
        st_next.carrier_n = 1'b1;
        st_next.cd_cnt = '0;
      end else begin
        st_next.cd_cnt = st_reg.cd_cnt + 24'h1;
      end
    end else begin
      st_next.cd_cnt = '0;
    end
    // Tone flag: guard plus detect time in each direction
    if (!dec[1]) begin
      st_next.tone_n = 1'b1;
      st_next.tone_cnt = '0;
    end else if (st_reg.tone_s[1] == st_reg.tone_n) begin
      if (st_reg.tone_n && st_reg.tone_cnt >= 24'(TREC - 1)) begin
        st_next.tone_n = 1'b0;
        st_next.tone_cnt = '0;
      end else if (!st_reg.tone_n &&
                   st_reg.tone_cnt >= 24'(TABS - 1)) begin
        st_next.tone_n = 1'b1;
        st_next.tone_cnt = '0;
      end else begin
        st_next.tone_cnt = st_reg.tone_cnt + 24'h1;
      end
    end else begin
      st_next.tone_cnt = '0; // A break in the condition restarts the guard
    end
    // Data only while carrier is present, to hide line noise
    st_next.data = st_reg.carrier_n ? 1'b1 : st_reg.bit_s[1];
    st_next.ferr = !st_next.carrier_n && st_reg.ferr_s[1] &&
                   !st_reg.ferr_s[2];
  end

  // State register
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      st_reg <= '{pd_en_tone: 3'h4, carrier_n: 1'b1, tone_n: 1'b1,
                  data: 1'b1, default: '0};
    end else if (ce_in) begin
      st_reg <= st_next;
    end
  end

  assign link.carrier_present_n = st_reg.carrier_n;
  assign link.ready_or_tone_flag_n = st_reg.tone_n;
  assign link.fsk_data = st_reg.data;
  assign link.frame_err = st_reg.ferr;
  assign pwr_down_out = st_reg.pd_en_tone[2];
  assign fsk_on_out = st_reg.pd_en_tone[1];
  assign tone_on_out = st_reg.pd_en_tone[0];
  assign tone_hybrid_out = st_reg.hyb;
endmodule : crs_device
`default_nettype wire

// [design/crs_host.sv]
// Host end: sequences the receiver for one caller data session
//
// Implementation choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "crs_params.svh"
// Operation
// - Receiver enables come from decoded select lines.
// - Ringing never raises carrier present.
// - Enable receiver only after ringing ends.
// - Power down after carrier present goes inactive.
// - Time out waiting for carrier present.
// - Leave FSK on carrier loss, errors, steady tone.
// - FSK mode only while data expected.
// - Off-hook: FSK right after acknowledge tone.
// - Acknowledge digit D, or A for ADSI.
// - No data off-hook: unmute, keypad on.
// - Recognition time is guard plus detect.
// - Absent time is guard plus detect.
// - Apply loads right after tone flag rises.
// - Remove loads 50-150ms after carrier ends.
// - Apply terminations right after ring ends.
// - Remove terminations, leave FSK at data end; this design holds terminations HOLD_CYC past data end.
module crs_host #(
  parameter int CD_TMO_CYC = `CRS_CD_TMO_MS * `CRS_CYC_PER_MS,
  parameter int NOFSK_CYC = `CRS_NOFSK_MS * `CRS_CYC_PER_MS,
  parameter int MS_CYC = `CRS_MARKSPACE_MS * `CRS_CYC_PER_MS,
  parameter int HOLD_CYC = `CRS_LOAD_HOLD_MS * `CRS_CYC_PER_MS
) (
  // Clock, reset, enable
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic ce_in,
  // Link to the receiver
  crs_link_if.host link,
  // Software register port
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out,
  output logic irq_out,
  // Telephone equipment
  input wire logic ring_active_in,
  input wire logic ack_done_in,
  output logic ack_req_out,
  output logic [3:0] ack_digit_out,
  output logic line_term_out,
  output logic mute_out,
  output logic keypad_en_out
);
  generate
    if (CD_TMO_CYC < 1 || NOFSK_CYC < 1 || MS_CYC < 1 || HOLD_CYC < 1 ||
        CD_TMO_CYC >= 2**24 || NOFSK_CYC >= 2**24 ||
        MS_CYC >= 2**24 || HOLD_CYC >= 2**24) begin : g_bad
      $error("crs_host timing parameters out of range");
    end
  endgenerate

  typedef struct packed {
    crs_pkg::crs_hstate_t fsm;
    crs_pkg::crs_mode_t mode;
    logic adsi;
    logic [2:0] cs;
    logic [23:0] tmr;
    logic [23:0] ms_cnt;
    logic [2:0] ferr_cnt;
    logic last_bit;
    logic [1:0] cd_s;
    logic [1:0] tf_s;
    logic [1:0] ring_s;
    logic [1:0] ackd_s;
    logic tf_old;
    logic [`CRS_EV_W-1:0] status;
    logic [`CRS_EV_W-1:0] enable;
    logic [31:0] rdata;
    logic ack_req;
    logic [3:0] ack_digit;
    logic term;
    logic mute;
  } crs_host_t;

  crs_host_t st_reg, st_next;
  logic [`CRS_EV_W-1:0] ev;
  logic tf_rise;
  logic ms_hit;

  always_comb begin
    st_next = st_reg;
    ev = '0;
    // Carrier, tone flag and equipment pins pass two flops; fsk_data and frame_err are used directly
    st_next.cd_s = {st_reg.cd_s[0], link.carrier_present_n};
    st_next.tf_s = {st_reg.tf_s[0], link.ready_or_tone_flag_n};
    st_next.ring_s = {st_reg.ring_s[0], ring_active_in};
    st_next.ackd_s = {st_reg.ackd_s[0], ack_done_in};
    st_next.tf_old = st_reg.tf_s[1];
    tf_rise = st_reg.tf_s[1] && !st_reg.tf_old;
    st_next.tmr = st_reg.tmr + 24'h1;
    ms_hit = 1'b0;
    case (st_reg.fsm)
      crs_pkg::H_IDLE: begin
        st_next.cs = `CRS_CS_POWER_DOWN_CTL;
        st_next.term = 1'b0;
        if (wr_in && addr_in == `CRS_A_CTRL &&
            wdata_in[`CRS_CTRL_START]) begin
          st_next.mode = crs_pkg::crs_mode_t'(
            wdata_in[`CRS_CTRL_MODE_LO +: 2]);
          st_next.adsi = wdata_in[`CRS_CTRL_ADSI];
          st_next.tmr = '0;
          case (wdata_in[`CRS_CTRL_MODE_LO +: 2])
            2'h0: st_next.fsm = crs_pkg::H_RING_WAIT;
            2'h1: begin
              st_next.fsm = crs_pkg::H_TONE_WAIT;
              st_next.cs = `CRS_CS_TONE_TR;
            end
            2'h2: begin
              st_next.fsm = crs_pkg::H_TONE_WAIT;
              st_next.cs = `CRS_CS_TONE_HYB;
              st_next.mute = 1'b1;
            end
            default: st_next.fsm = crs_pkg::H_IDLE;
          endcase
        end
      end
      crs_pkg::H_RING_WAIT: begin
        // Receiver stays down through ringing to save battery
        if (!st_reg.ring_s[1]) begin
          st_next.term = 1'b1;
          st_next.cs = `CRS_CS_FSK;
          st_next.tmr = '0;
          st_next.fsm = crs_pkg::H_CD_WAIT;
        end
      end
      crs_pkg::H_TONE_WAIT: begin
        if (!st_reg.tf_s[1]) begin
          st_next.fsm = crs_pkg::H_TONE_END;
        end
      end
      crs_pkg::H_TONE_END: begin
        if (tf_rise) begin
          st_next.tmr = '0;
          if (st_reg.mode == crs_pkg::MODE_OFFHOOK) begin
            st_next.cs = `CRS_CS_POWER_DOWN_CTL;
            st_next.ack_req = 1'b1;
            st_next.ack_digit = st_reg.adsi ? `CRS_ACK_ADSI
                                            : `CRS_ACK_PLAIN;
            st_next.fsm = crs_pkg::H_ACK;
          end else begin
            st_next.term = 1'b1;
            st_next.cs = `CRS_CS_FSK;
            st_next.fsm = crs_pkg::H_CD_WAIT;
          end
        end
      end
      crs_pkg::H_ACK: begin
        if (st_reg.ackd_s[1]) begin
          st_next.ack_req = 1'b0;
          st_next.cs = `CRS_CS_FSK;
          st_next.tmr = '0;
          st_next.fsm = crs_pkg::H_CD_WAIT;
        end
      end
      crs_pkg::H_CD_WAIT: begin
        st_next.ferr_cnt = '0;
        st_next.ms_cnt = '0;
        st_next.last_bit = link.fsk_data;
        if (!st_reg.cd_s[1]) begin
          ev[`CRS_EV_CARRIER] = 1'b1;
          st_next.fsm = crs_pkg::H_RECV;
        end else if (st_reg.mode == crs_pkg::MODE_OFFHOOK &&
                     st_reg.tmr >= 24'(NOFSK_CYC - 1)) begin
          ev[`CRS_EV_NOFSK] = 1'b1;
          st_next.mute = 1'b0;
          st_next.cs = `CRS_CS_POWER_DOWN_CTL;
          st_next.fsm = crs_pkg::H_IDLE;
        end else if (st_reg.mode != crs_pkg::MODE_OFFHOOK &&
                     st_reg.tmr >= 24'(CD_TMO_CYC - 1)) begin
          ev[`CRS_EV_CD_TMO] = 1'b1;
          st_next.cs = `CRS_CS_POWER_DOWN_CTL;
          st_next.term = 1'b0;
          st_next.fsm = crs_pkg::H_IDLE;
        end
      end
      crs_pkg::H_RECV: begin
        // Steady mark or space measured on our own timer
        st_next.last_bit = link.fsk_data;
        if (link.fsk_data != st_reg.last_bit) begin
          st_next.ms_cnt = '0;
        end else begin
          st_next.ms_cnt = st_reg.ms_cnt + 24'h1;
        end
        ms_hit = st_reg.ms_cnt >= 24'(MS_CYC - 1);
        // Errors need not be consecutive, so nothing in H_RECV clears the count
        if (link.frame_err) begin
          st_next.ferr_cnt = st_reg.ferr_cnt + 3'h1;
        end
        ev[`CRS_EV_FERR] = st_next.ferr_cnt >= 3'(`CRS_FERR_MAX);
        ev[`CRS_EV_MARKSPACE] = ms_hit;
        if (st_reg.cd_s[1] || ev[`CRS_EV_FERR] || ms_hit) begin
          st_next.cs = `CRS_CS_POWER_DOWN_CTL;
          st_next.tmr = '0;
          st_next.fsm = crs_pkg::H_END_HOLD;
        end
      end
      crs_pkg::H_END_HOLD: begin
        if (st_reg.tmr >= 24'(HOLD_CYC - 1)) begin
          st_next.term = 1'b0;
          st_next.mute = 1'b0;
          ev[`CRS_EV_DONE] = 1'b1;
          st_next.fsm = crs_pkg::H_IDLE;
        end
      end
      default: st_next.fsm = crs_pkg::H_IDLE;
    endcase
    // Abort wins over any session step
    if (wr_in && addr_in == `CRS_A_CTRL && wdata_in[`CRS_CTRL_ABORT]) begin
      st_next.fsm = crs_pkg::H_IDLE;
      st_next.cs = `CRS_CS_POWER_DOWN_CTL;
      st_next.term = 1'b0;
      st_next.mute = 1'b0;
      st_next.ack_req = 1'b0;
    end
    // Register writes; a new event beats a clear in the same cycle
    if (wr_in && addr_in == `CRS_A_ENABLE) begin
      st_next.enable = wdata_in[`CRS_EV_W-1:0];
    end
    if (wr_in && addr_in == `CRS_A_CLEAR) begin
      st_next.status = st_reg.status & ~wdata_in[`CRS_EV_W-1:0];
    end
    st_next.status = st_next.status | ev;
    // Read data stands in the following cycle only
    st_next.rdata = '0;
    if (rd_in) begin
      case (addr_in)
        `CRS_A_CTRL: st_next.rdata = {28'h0, st_reg.adsi, st_reg.mode, 1'b0};
        `CRS_A_STATUS: st_next.rdata = {26'h0, st_reg.status};
        `CRS_A_ENABLE: st_next.rdata = {26'h0, st_reg.enable};
        `CRS_A_STATE: st_next.rdata = {20'h0, st_reg.ferr_cnt,
          st_reg.term, st_reg.mute, st_reg.cs, 4'(st_reg.fsm)};
        default: st_next.rdata = '0;
      endcase
    end
  end

  // State register
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      st_reg <= '{fsm: crs_pkg::H_IDLE, mode: crs_pkg::MODE_RING,
                  cs: `CRS_CS_POWER_DOWN_CTL, cd_s: 2'h3, tf_s: 2'h3,
                  tf_old: 1'b1, last_bit: 1'b1, default: '0};
    end else if (ce_in) begin
      st_reg <= st_next;
    end
  end

  assign link.control_select_lines = st_reg.cs;
  assign rdata_out = st_reg.rdata;
  assign irq_out = |(st_reg.status & st_reg.enable);
  assign ack_req_out = st_reg.ack_req;
  assign ack_digit_out = st_reg.ack_digit;
  assign line_term_out = st_reg.term;
  assign mute_out = st_reg.mute;
  assign keypad_en_out = !st_reg.mute;
endmodule : crs_host
`default_nettype wire

// [sim/crs_link_properties.sv]
// Link pin checker for the caller data receive sequencer
`timescale 1ns/1ps
`default_nettype none
module crs_link_properties #(
  parameter int CD_ON_CYC = 40,
  parameter int TONE_CYC = 40,
  parameter int WAIT_CYC = 300
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // Link pins
  input wire logic [2:0] control_select_lines,
  input wire logic carrier_present_n,
  input wire logic ready_or_tone_flag_n,
  input wire logic fsk_data,
  input wire logic frame_err
);
  logic [15:0] fsk_run_reg;
  logic [15:0] tone_run_reg;
  logic [15:0] wait_run_reg;
  logic [2:0] ferr_cnt_reg;
  logic fsk_sel;
  logic tone_sel;
  // Decoded select codes
  assign fsk_sel = control_select_lines == 3'h4;
  assign tone_sel = control_select_lines inside {3'h1, 3'h2};
  // Run lengths per code; the device can only be slower than these
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      fsk_run_reg <= 16'h0;
      tone_run_reg <= 16'h0;
      wait_run_reg <= 16'h0;
      ferr_cnt_reg <= 3'h0;
    end else begin
      fsk_run_reg <= fsk_sel ? fsk_run_reg + 16'h1 : 16'h0;
      tone_run_reg <= tone_sel ? tone_run_reg + 16'h1 : 16'h0;
      wait_run_reg <= (fsk_sel && carrier_present_n) ?
        wait_run_reg + 16'h1 : 16'h0;
      ferr_cnt_reg <= fsk_sel ? ferr_cnt_reg + {2'h0, frame_err} : 3'h0;
    end
  end
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  property p_legal_code;
    control_select_lines inside {3'h0, 3'h1, 3'h2, 3'h4};
  endproperty
  a_legal_code: assert property (p_legal_code)
    else $error("select code outside decoded set");
  property p_carrier_code;
    !fsk_sel [*3] |-> carrier_present_n;
  endproperty
  a_carrier_code: assert property (p_carrier_code)
    else $error("carrier present without fsk code");
  property p_flag_code;
    !tone_sel [*3] |-> ready_or_tone_flag_n;
  endproperty
  a_flag_code: assert property (p_flag_code)
    else $error("tone flag without tone code");
  property p_carrier_qual;
    $fell(carrier_present_n) |-> fsk_run_reg >= CD_ON_CYC;
  endproperty
  a_carrier_qual: assert property (p_carrier_qual)
    else $error("carrier present too early");
  property p_tone_qual;
    $fell(ready_or_tone_flag_n) |-> tone_run_reg >= TONE_CYC;
  endproperty
  a_tone_qual: assert property (p_tone_qual)
    else $error("tone flag before guard and detect time");
  property p_ferr_pulse;
    frame_err |-> !carrier_present_n ##1 !frame_err;
  endproperty
  a_ferr_pulse: assert property (p_ferr_pulse)
    else $error("framing error pulse malformed");
  property p_data_idle;
    carrier_present_n [*3] |-> fsk_data;
  endproperty
  a_data_idle: assert property (p_data_idle)
    else $error("data not idle without carrier");
  property p_leave_fsk;
    $rose(carrier_present_n) && fsk_sel |-> ##[1:6] !fsk_sel;
  endproperty
  a_leave_fsk: assert property (p_leave_fsk)
    else $error("fsk code kept after carrier loss");
  property p_ferr_exit;
    ferr_cnt_reg == 3'h5 |-> ##[0:3] !fsk_sel;
  endproperty
  a_ferr_exit: assert property (p_ferr_exit)
    else $error("fsk code kept after framing errors");
  property p_wait_bound;
    int'(wait_run_reg) <= WAIT_CYC + 16;
  endproperty
  a_wait_bound: assert property (p_wait_bound)
    else $error("carrier wait not abandoned");
  // Main scenarios reached
  c_carrier: cover property ($fell(carrier_present_n));
  c_tone: cover property ($rose(ready_or_tone_flag_n));
  c_ferr: cover property (ferr_cnt_reg == 3'h5);
  c_wait: cover property (int'(wait_run_reg) == WAIT_CYC);
endmodule : crs_link_properties
`default_nettype wire

// [sim/callerid_receive_sequencer_tb_top.sv]
// Self-checking bench joining both ends of the receive sequencer
`timescale 1ns/1ps
`default_nettype none
`include "crs_params.svh"
module callerid_receive_sequencer_tb_top;
  localparam int TONE = 20;
  localparam int CD_ON = 40;
  localparam int CD_OFF = 20;
  localparam int TMO = 300;
  localparam int HOLD = 60;
  typedef struct packed {
    logic [1:0] mode;
    logic adsi;
    logic [1:0] kind;
    logic [5:0] mask;
    logic [5:0] exp;
  } crs_row_t;
  // Kind 0 carrier loss, 1 framing errors, 2 steady data, 3 no carrier
  crs_row_t rows [7] = '{'{2'h0, 1'b0, 2'h0, 6'h3f, 6'h03},
    '{2'h1, 1'b0, 2'h0, 6'h3f, 6'h03}, '{2'h2, 1'b0, 2'h0, 6'h3f, 6'h03},
    '{2'h2, 1'b1, 2'h1, 6'h3f, 6'h0b}, '{2'h0, 1'b0, 2'h2, 6'h3f, 6'h13},
    '{2'h1, 1'b0, 2'h3, 6'h3d, 6'h04}, '{2'h2, 1'b0, 2'h3, 6'h3d, 6'h20}};
  logic clk_sys_in = 1'b0;
  logic rst_in = 1'b1;
  logic ring = 1'b0, ring_act = 1'b0, fsk_en = 1'b0, tone_en = 1'b0;
  logic fbit = 1'b1, ferr = 1'b0, ack_done = 1'b0, wr = 1'b0, rd = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata, rd_val;
  logic irq, ack_req, term, mute, keypad, pwr_down, fsk_on, tone_on, hyb;
  logic [3:0] ack_digit;
  int mismatches = 0;
  int n_tests = 0;
  crs_link_if link ();
  // Short counts keep each session a few hundred cycles long
  crs_device #(.GP_CYC(TONE), .DP_CYC(TONE), .GA_CYC(TONE), .DA_CYC(TONE),
    .CD_ON_CYC(CD_ON), .CD_OFF_CYC(CD_OFF)) i_crs_device (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .ce_in(1'b1), .link(link),
    .ring_detect_in(ring), .fsk_energy_in(fsk_en), .tone_energy_in(tone_en),
    .fsk_bit_in(fbit), .frame_err_in(ferr), .pwr_down_out(pwr_down),
    .fsk_on_out(fsk_on), .tone_on_out(tone_on), .tone_hybrid_out(hyb));
  crs_host #(.CD_TMO_CYC(TMO), .NOFSK_CYC(TMO), .MS_CYC(200),
    .HOLD_CYC(HOLD)) i_crs_host (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .ce_in(1'b1), .link(link),
    .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
    .rdata_out(rdata), .irq_out(irq), .ring_active_in(ring_act),
    .ack_done_in(ack_done), .ack_req_out(ack_req),
    .ack_digit_out(ack_digit), .line_term_out(term), .mute_out(mute),
    .keypad_en_out(keypad));
  crs_link_properties #(.CD_ON_CYC(CD_ON), .TONE_CYC(2 * TONE),
    .WAIT_CYC(TMO)) i_crs_link_properties (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in),
    .control_select_lines(link.control_select_lines),
    .carrier_present_n(link.carrier_present_n),
    .ready_or_tone_flag_n(link.ready_or_tone_flag_n),
    .fsk_data(link.fsk_data), .frame_err(link.frame_err));
  // Clock generator
  always #50 clk_sys_in = ~clk_sys_in;
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_in);
  endtask : cyc
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys_in);
    wr <= 1'b0;
  endtask : reg_wr
  // Read data stand only in the cycle after the strobe
  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys_in);
    rd <= 1'b0;
    @(negedge clk_sys_in);
    d = rdata;
  endtask : reg_rd
  task automatic chk_word(input string what, input logic [31:0] exp,
    input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_word
  task automatic chk_bit(input string what, input logic exp,
    input logic got);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %b seen %b", what, exp, got);
    end
  endtask : chk_bit
  // One whole session from start to the status read and clear
  task automatic session(input crs_row_t r);
    logic [31:0] st;
    int j;
    // Ringing must already be seen when the session starts
    if (r.mode == 2'h0) begin
      cyc(1);
      ring <= 1'b1;
      ring_act <= 1'b1;
      cyc(3);
    end
    reg_wr(`CRS_A_CTRL, {27'h0, 1'b0, r.adsi, r.mode, 1'b1});
    if (r.mode == 2'h0) begin
      cyc(30);
      @(negedge clk_sys_in);
      chk_bit("off in ring", 1'b1, pwr_down);
      chk_bit("ring carrier", 1'b1, link.carrier_present_n);
      cyc(1);
      ring <= 1'b0;
      ring_act <= 1'b0;
    end else begin
      cyc(10);
      @(negedge clk_sys_in);
      chk_bit("tone detect", 1'b1, tone_on);
      cyc(1);
      tone_en <= 1'b1;
      cyc(2 * TONE + 10);
      @(negedge clk_sys_in);
      chk_bit("tone flag", 1'b0, link.ready_or_tone_flag_n);
      cyc(1);
      tone_en <= 1'b0;
      cyc(2 * TONE + 20);
    end
    @(negedge clk_sys_in);
    if (r.mode == 2'h2) begin
      chk_bit("ack request", 1'b1, ack_req);
      chk_word("ack digit", {28'h0, r.adsi ? `CRS_ACK_ADSI : `CRS_ACK_PLAIN},
        {28'h0, ack_digit});
      chk_bit("fsk during ack", 1'b0, fsk_on);
      cyc(1);
      ack_done <= 1'b1;
      cyc(8);
      ack_done <= 1'b0;
    end else begin
      cyc(10);
      @(negedge clk_sys_in);
      chk_bit("terminations", 1'b1, term);
    end
    cyc(6);
    @(negedge clk_sys_in);
    chk_bit("fsk mode", 1'b1, fsk_on);
    if (r.kind == 2'h3) begin
      cyc(TMO + HOLD + 40);
    end else begin
      cyc(1);
      fsk_en <= 1'b1;
      cyc(CD_ON + 10);
      @(negedge clk_sys_in);
      chk_bit("carrier", 1'b0, link.carrier_present_n);
      reg_rd(`CRS_A_STATE, st);
      chk_word("error count", 32'h0, st & 32'h00000e00);
      // Steps of four cycles; kind 1 errors on five of them, bits toggling except held low in kind 2
      for (j = 0; j < 60; j++) begin
        @(posedge clk_sys_in);
        fbit <= (r.kind == 2'h2) ? 1'b0 : j[0];
        ferr <= (r.kind == 2'h1) && (j < 10) && j[0];
        cyc(3);
      end
      fsk_en <= 1'b0;
      cyc(CD_OFF + 15);
      @(negedge clk_sys_in);
      chk_bit("powered down", 1'b1, pwr_down);
      if (r.kind == 2'h0 && r.mode != 2'h2) begin
        chk_bit("loads held", 1'b1, term);
      end
      cyc(HOLD + 10);
    end
    @(negedge clk_sys_in);
    chk_bit("loads removed", 1'b0, term);
    if (r.mode == 2'h2 && r.kind == 2'h3) begin
      chk_bit("unmuted", 1'b0, mute);
      chk_bit("keypad", 1'b1, keypad);
    end
    reg_rd(`CRS_A_STATUS, st);
    chk_word("status", {26'h0, r.exp}, st & {26'h0, r.mask});
    chk_bit("interrupt", 1'b1, irq);
    reg_wr(`CRS_A_CLEAR, 32'h0000003f);
    cyc(2);
    @(negedge clk_sys_in);
    chk_bit("interrupt cleared", 1'b0, irq);
  endtask : session
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : summarize
  // Main sequence: table rows, then masking, unmapped read, reset
  initial begin
    cyc(2);
    rst_in <= 1'b0;
    @(negedge clk_sys_in);
    chk_word("select at reset", 32'h0, {29'h0, link.control_select_lines});
    chk_bit("flag at reset", 1'b1, link.ready_or_tone_flag_n);
    chk_bit("data at reset", 1'b1, link.fsk_data);
    reg_wr(`CRS_A_ENABLE, 32'h0000003f);
    foreach (rows[i]) session(rows[i]);
    reg_wr(`CRS_A_ENABLE, 32'h0);
    reg_wr(`CRS_A_CTRL, 32'h00000001);
    // Ringing energy beside FSK energy under the FSK code
    ring <= 1'b1;
    fsk_en <= 1'b1;
    cyc(CD_ON + 20);
    @(negedge clk_sys_in);
    chk_bit("carrier in ringing", 1'b1, link.carrier_present_n);
    cyc(1);
    ring <= 1'b0;
    fsk_en <= 1'b0;
    cyc(TMO + HOLD + 80);
    @(negedge clk_sys_in);
    chk_bit("masked interrupt", 1'b0, irq);
    reg_rd(`CRS_A_STATUS, rd_val);
    chk_word("timeout status", 32'h4, rd_val & 32'h4);
    reg_wr(`CRS_A_ENABLE, 32'h00000004);
    reg_rd(8'h20, rd_val);
    chk_word("unmapped read", 32'h0, rd_val);
    chk_bit("unmasked interrupt", 1'b1, irq);
    reg_wr(`CRS_A_CTRL, 32'h00000005);
    cyc(10);
    @(negedge clk_sys_in);
    chk_word("hybrid code", 32'h2, {29'h0, link.control_select_lines});
    chk_bit("hybrid enable", 1'b1, hyb);
    reg_wr(`CRS_A_CTRL, 32'h00000010);
    @(negedge clk_sys_in);
    chk_bit("abort unmute", 1'b0, mute);
    reg_wr(`CRS_A_CTRL, 32'h00000005);
    cyc(1);
    rst_in <= 1'b1;
    cyc(2);
    rst_in <= 1'b0;
    @(negedge clk_sys_in);
    chk_word("select after reset", 32'h0, {29'h0, link.control_select_lines});
    chk_bit("mute after reset", 1'b0, mute);
    chk_bit("irq after reset", 1'b0, irq);
    reg_rd(`CRS_A_STATUS, rd_val);
    chk_word("status after reset", 32'h0, rd_val);
    summarize();
  end
  // Watchdog well beyond the expected run length
  initial begin
    cyc(20000);
    mismatches++;
    summarize();
  end
endmodule : callerid_receive_sequencer_tb_top
`default_nettype wire
